// >>> design/sbc_top.sv
`timescale 1ns/1ns
`include "sbc_map.svh"
module sbc_top (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   clear_pulse,
   input  wire logic                   serial_bit,
   input  wire logic                   word_enable,
   input  wire logic                   print_all,
   output logic                        shift_pulse,
   output logic                        busy,
   output logic                        end_conv,
   output logic                        print_cmd,
   output logic [`SBC_BCD_W-1:0]       print_digits,
   output logic [`SBC_BCD_W-1:0]       display_digits
);
   sbc_pulse_if pul ();

   logic                     run_q;
   logic [`SBC_TICK_W-1:0]   tick_q;
   logic                     tick;
   sbc_pkg::sbc_phase_t      ph_q;
   logic [`SBC_CNT_W-1:0]    cnt_q;
   logic                     last;
   logic                     sel_q;
   logic                     done_q;
   logic                     prn_q;
   logic [`SBC_BCD_W-1:0]    store_q;
   logic [`SBC_BCD_W-1:0]    bcd;
   logic [`SBC_DIGITS:0]     chain;

   assign tick = run_q && (tick_q == `SBC_TICK_W'(`SBC_TICK_CYC - 1));
   assign pul.strobe = tick && (ph_q == sbc_pkg::SBC_PH_STROBE);
   assign pul.add1   = tick && (ph_q == sbc_pkg::SBC_PH_ADD1);
   assign pul.add2   = tick && (ph_q == sbc_pkg::SBC_PH_ADD2);
   assign pul.shift  = tick && (ph_q == sbc_pkg::SBC_PH_SHIFT);
   assign last = pul.shift && (cnt_q == `SBC_CNT_W'(`SBC_WORD_BITS - 1));
   assign shift_pulse = pul.shift;
   assign busy = run_q;
   assign end_conv = done_q;
   assign print_cmd = prn_q;
   assign print_digits = store_q;
   assign display_digits = store_q;
   assign chain[0] = serial_bit;

   genvar g;
   generate
      for (g = 0; g < `SBC_DIGITS; g = g + 1) begin : g_dig
         sbc_digit u_dig (
            .clk       (clk),
            .nrst      (nrst),
            .clr       (clear_pulse),
            .pul       (pul),
            .carry_in  (chain[g]),
            .digit     (bcd[4*g+3:4*g]),
            .carry_out (chain[g+1])
         );
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!nrst) begin
         run_q <= 1'b0;
      end else if (clear_pulse) begin
         run_q <= 1'b1;
      end else if (last) begin
         run_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || clear_pulse || tick) begin
         tick_q <= `SBC_TICK_W'h0;
      end else if (run_q) begin
         tick_q <= tick_q + `SBC_TICK_W'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || clear_pulse) begin
         ph_q <= sbc_pkg::SBC_PH_STROBE;
      end else if (tick) begin
         unique case (ph_q)
            sbc_pkg::SBC_PH_STROBE: ph_q <= sbc_pkg::SBC_PH_ADD1;
            sbc_pkg::SBC_PH_ADD1:   ph_q <= sbc_pkg::SBC_PH_ADD2;
            sbc_pkg::SBC_PH_ADD2:   ph_q <= sbc_pkg::SBC_PH_SHIFT;
            sbc_pkg::SBC_PH_SHIFT:  ph_q <= sbc_pkg::SBC_PH_STROBE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || clear_pulse) begin
         cnt_q <= `SBC_CNT_W'h0;
      end else if (pul.shift) begin
         cnt_q <= cnt_q + `SBC_CNT_W'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sel_q <= 1'b0;
      end else if (clear_pulse) begin
         sel_q <= print_all | word_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_q <= 1'b0;
         prn_q  <= 1'b0;
      end else begin
         done_q <= last;
         prn_q  <= last && sel_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         store_q <= `SBC_BCD_W'h0;
      end else if (done_q && sel_q) begin
         store_q <= bcd;
      end
   end
endmodule

// >>> design/sbc_map.svh
// Function
// - Take word MSB first, output decimal
// - Register of 28 bits, seven digits
// - Shift moves every bit up one stage
// - Add three to digits five through nine
// - Clear pulse starts 1 MHz conversion clock
// - Phase 00 gives strobe, goes 01
// - Phase 01 gives add-1, goes 10
// - Phase 10 gives add-2, goes 11
// - Phase 11 gives shift, goes 00
// - Strobe sets flag when digit is five+
// - Digit below five stays unchanged
// - All digits tested at same strobe
// - Register zero when conversion begins
// - Storage flops hold finished digits
// - Print pulses, any words selectable
// - Stop after 21 shifts, command print only for a selected word
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_DIGITS       7
`define SBC_BCD_W        28
`define SBC_WORD_BITS    21
`define SBC_CNT_W        5
`define SBC_SYS_HZ       50000000
`define SBC_CONV_HZ      1000000
`define SBC_TICK_CYC     (`SBC_SYS_HZ / `SBC_CONV_HZ)
`define SBC_TICK_W       6
`define SBC_THRESH       4'h5
`define SBC_ADD1         4'h1
`define SBC_ADD2         4'h2
`endif

// >>> design/sbc_pkg.sv
package sbc_pkg;
   typedef enum logic [1:0] {
      SBC_PH_STROBE = 2'b00,
      SBC_PH_ADD1   = 2'b01,
      SBC_PH_ADD2   = 2'b10,
      SBC_PH_SHIFT  = 2'b11
   } sbc_phase_t;
endpackage

// >>> design/sbc_pulse_if.sv
`timescale 1ns/1ns
interface sbc_pulse_if;
   logic strobe;
   logic add1;
   logic add2;
   logic shift;
   modport src (output strobe, output add1, output add2, output shift);
   modport dst (input strobe, input add1, input add2, input shift);
endinterface

// >>> design/sbc_digit.sv
`timescale 1ns/1ns
`include "sbc_map.svh"
module sbc_digit (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       clr,
   sbc_pulse_if.dst        pul,
   input  wire logic       carry_in,
   output logic [3:0]      digit,
   output logic            carry_out
);
   logic [3:0] dig_q;
   logic       flag_q;

   assign digit     = dig_q;
   assign carry_out = dig_q[3];

   always_ff @(posedge clk) begin
      if (!nrst || clr) begin
         flag_q <= 1'b0;
      end else if (pul.strobe) begin
         flag_q <= dig_q[3] | (dig_q[2] & dig_q[1]) | (dig_q[2] & dig_q[0]);
      end else if (pul.add2) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || clr) begin
         dig_q <= 4'h0;
      end else if (pul.add1 && flag_q) begin
         dig_q <= dig_q + `SBC_ADD1;
      end else if (pul.add2 && flag_q) begin
         dig_q <= dig_q + `SBC_ADD2;
      end else if (pul.shift) begin
         dig_q <= {dig_q[2:0], carry_in};
      end
   end
endmodule

// >>> verification/sbc_feeder.sv
`timescale 1ns/1ns
module sbc_feeder (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        load,
   input  wire logic [20:0] word,
   input  wire logic        shift_pulse,
   output logic             serial_bit
);
   logic [20:0] hold_q;
   always_ff @(posedge clk) begin
      if (!nrst) hold_q <= 21'h0;
      else if (load) hold_q <= word;
      else if (shift_pulse) hold_q <= {hold_q[19:0], 1'b0};
   end
   assign serial_bit = hold_q[20];
endmodule

// >>> verification/sbc_top_asserts.sv
`timescale 1ns/1ns
`include "sbc_map.svh"
module sbc_top_asserts (
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire logic                  clear_pulse,
   input wire logic                  shift_pulse,
   input wire logic                  busy,
   input wire logic                  end_conv,
   input wire logic                  print_cmd,
   input wire logic [`SBC_BCD_W-1:0] print_digits,
   input wire logic [`SBC_BCD_W-1:0] display_digits
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_pc; print_cmd |-> end_conv; endproperty
   property p_go; clear_pulse |=> busy; endproperty
   property p_first; clear_pulse |-> ##200 shift_pulse; endproperty
   property p_gap; shift_pulse |=> !shift_pulse [*8]; endproperty
   property p_end; end_conv |-> !busy && !shift_pulse; endproperty
   property p_fell; $fell(busy) |-> end_conv; endproperty
   property p_same; print_digits == display_digits; endproperty
   property p_keep; $changed(print_digits) |-> $past(end_conv); endproperty
   a_pc: assert property (p_pc) else $error("print without end");
   a_go: assert property (p_go) else $error("not busy");
   a_first: assert property (p_first) else $error("shift late");
   a_gap: assert property (p_gap) else $error("shift early");
   a_end: assert property (p_end) else $error("end busy");
   a_fell: assert property (p_fell) else $error("busy fell");
   a_same: assert property (p_same) else $error("outputs differ");
   a_keep: assert property (p_keep) else $error("digits moved");
   c_pr: cover property (print_cmd);
   c_np: cover property (end_conv && !print_cmd);
   c_sh: cover property (shift_pulse);
   c_rs: cover property (busy && clear_pulse);
endmodule
bind sbc_top sbc_top_asserts sbc_top_asserts_i (.clk, .nrst, .clear_pulse, .shift_pulse,
   .busy, .end_conv, .print_cmd, .print_digits, .display_digits);

// >>> verification/serial_binary_to_bcd_converter_tb_top.sv
`timescale 1ns/1ns
`include "sbc_map.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
   $display("Error %s exp %h got %h", n, e, a); end end
module serial_binary_to_bcd_converter_tb_top;
   logic        clk = 1'b0, nrst = 1'b0, clear_pulse = 1'b0, load = 1'b0;
   logic        word_enable = 1'b0, print_all = 1'b0;
   logic [20:0] word = 21'h0;
   logic        serial_bit, shift_pulse, busy, end_conv, print_cmd;
   logic [27:0] print_digits, display_digits;
   int          errors = 0, tests_run = 0;
   always #10 clk = ~clk;
   sbc_feeder sbc_feeder_i (.clk, .nrst, .load, .word, .shift_pulse, .serial_bit);
   sbc_top sbc_top_i (.clk, .nrst, .clear_pulse, .serial_bit, .word_enable, .print_all,
      .shift_pulse, .busy, .end_conv, .print_cmd, .print_digits, .display_digits);
   task automatic run(input logic [20:0] w, input logic we, pa, sel, input logic [27:0] ex);
      int k;
      @(posedge clk);
      word <= w;
      load <= 1'b1;
      word_enable <= we;
      print_all <= pa;
      clear_pulse <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      clear_pulse <= 1'b0;
      @(negedge clk);
      `CHK("busy", 1'b1, busy)
      for (k = 0; k < 5000 && end_conv !== 1'b1; k++) @(negedge clk);
      `CHK("end_conv", 1'b1, end_conv)
      `CHK("cycles", `SBC_TICK_CYC * 4 * `SBC_WORD_BITS, k)
      `CHK("busy_end", 1'b0, busy)
      `CHK("print_cmd", sel, print_cmd)
      @(negedge clk);
      `CHK("print", ex, print_digits)
      `CHK("display", ex, display_digits)
   endtask
   task t_max;
      run(21'h1fffff, 1'b0, 1'b1, 1'b1, 28'h2097151);
      $display("t_max done");
   endtask
   task t_skip;
      run(21'h003039, 1'b0, 1'b0, 1'b0, 28'h2097151);
      $display("t_skip done");
   endtask
   task t_ten;
      run(21'h00000a, 1'b1, 1'b0, 1'b1, 28'h0000010);
      $display("t_ten done");
   endtask
   task t_restart;
      @(posedge clk);
      word <= 21'h1fffff;
      load <= 1'b1;
      print_all <= 1'b1;
      clear_pulse <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      clear_pulse <= 1'b0;
      repeat (1000) @(posedge clk);
      run(21'h0004d2, 1'b1, 1'b0, 1'b1, 28'h0001234);
      $display("t_restart done");
   endtask
   task stop_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_max;
      t_skip;
      t_ten;
      t_restart;
      stop_test;
   end
   initial begin
      #600000;
      errors++;
      stop_test;
   end
endmodule
